// file: src/timer_capture_compare_unit.sv
`timescale 1ns/1ps
// Behaviour
// - external clock selection means event counting
// - same max rate for one/both edges
// - sampling clock fclk or divided 64/128/256
// - run set: zero, count next clock
// - run cleared: zero at once, stop
// - rewriting run one leaves counting alone
// - count match raises per-register match request
// - optional clear after compare match
// - valid edge captures count, held
// - capture edge follows edge mode setting
// - dual capture may clear counter
// - capture clear steps once before zero
// - two compares run independently
// - width bit selects 8 or 16 bits
// - match/capture clear waits next count clock
// - all-ones wraps, sets sticky overflow
module timer_capture_compare_unit
    import timer_pkg::*;
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    // avalon-mm slave
    input wire logic [ADDR_W-1:0] I_AVS_ADDRESS,
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [DATA_W-1:0] I_AVS_WRITEDATA,
    input wire logic [3:0] I_AVS_BYTEENABLE,
    output logic [DATA_W-1:0] O_AVS_READDATA,
    output logic O_AVS_WAITREQUEST,
    // external pulse pin
    input wire logic I_EXTERNAL_EDGE_INPUT,
    // requests to the interrupt controller
    output logic O_MATCH_IRQ_A,
    output logic O_MATCH_IRQ_B,
    output logic O_EDGE_IRQ
);

    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta_r;
    logic rst_n;

    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            rst_meta_r <= 1'b0;
            rst_n <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_n <= rst_meta_r;
        end
    end

    // ************************************************************
    // declarations
    // ************************************************************
    logic width_r;
    logic ovf_r;
    logic [3:0] prescale_r;
    logic clr_a_r;
    logic clr_b_r;
    logic cap_sel_r;
    logic [1:0] smp_sel_r;
    logic [1:0] edge_mode_r;
    logic [CNT_W-1:0] cmp_a_r;
    logic [CNT_W-1:0] dual_r;
    logic [CNT_W-1:0] capture_r;
    logic [CNT_W-1:0] count_r;
    logic [CNT_W-1:0] count_nxt;
    cnt_state_e state_r;
    cnt_state_e state_nxt;
    logic match_pend_r;
    logic cap_pend_r;
    logic step_clr_r;
    logic consume;
    logic [DIV_W-1:0] div_r;
    logic [DIV_W-1:0] pmask;
    logic int_tick;
    logic count_tick;
    logic smp_en;
    logic edge_pulse;
    logic inc;
    logic match_a;
    logic match_b;
    logic cap_evt;
    logic ovf_evt;
    logic [CNT_W-1:0] wmask;
    logic wr_accept;
    logic rd_load;
    logic wr_tc;
    logic [DATA_W-1:0] rd_mux;

    // ************************************************************
    // bus slave: one wait cycle per access
    // ************************************************************
    assign wr_accept = I_AVS_WRITE & ~O_AVS_WAITREQUEST;
    assign rd_load = I_AVS_READ & O_AVS_WAITREQUEST;
    assign wr_tc = wr_accept && (I_AVS_ADDRESS == OFF_TIMER_CONTROL)
        && I_AVS_BYTEENABLE[0];

    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
            O_AVS_WAITREQUEST <= 1'b1;
        else if ((I_AVS_READ | I_AVS_WRITE) && O_AVS_WAITREQUEST)
            O_AVS_WAITREQUEST <= 1'b0;
        else
            O_AVS_WAITREQUEST <= 1'b1;
    end

    function automatic logic [CNT_W-1:0] merge16(
        input logic [CNT_W-1:0] old,
        input logic [DATA_W-1:0] wd,
        input logic [3:0] be
    );
        logic [CNT_W-1:0] r;
        r = old;
        if (be[0])
            r[7:0] = wd[7:0];
        if (be[1])
            r[15:8] = wd[15:8];
        return r;
    endfunction

    always_comb
    begin
        rd_mux = '0;
        case (I_AVS_ADDRESS)
            OFF_TIMER_CONTROL:
            begin
                rd_mux[TC_WIDTH_BIT] = width_r;
                rd_mux[TC_OVF_BIT] = ovf_r;
                rd_mux[TC_RUN_BIT] = (state_r != ST_STOPPED);
            end
            OFF_PRESCALER_SELECT: rd_mux[3:0] = prescale_r;
            OFF_CC_CONTROL:
            begin
                rd_mux[CC_CLR_A_BIT] = clr_a_r;
                rd_mux[CC_CLR_B_BIT] = clr_b_r;
                rd_mux[CC_CAPTURE_BIT] = cap_sel_r;
            end
            OFF_SAMPLING_SELECT: rd_mux[1:0] = smp_sel_r;
            OFF_EDGE_MODE: rd_mux[1:0] = edge_mode_r;
            OFF_COMPARE_A: rd_mux[CNT_W-1:0] = cmp_a_r;
            OFF_DUAL: rd_mux[CNT_W-1:0] = dual_r;
            OFF_CAPTURE: rd_mux[CNT_W-1:0] = capture_r;
            OFF_TIMER_COUNT: rd_mux[CNT_W-1:0] = count_r;
            default: rd_mux = '0;
        endcase
    end

    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
            O_AVS_READDATA <= '0;
        else if (rd_load)
            O_AVS_READDATA <= rd_mux;
    end

    // ************************************************************
    // control registers
    // ************************************************************
    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            width_r <= 1'b0;
            prescale_r <= PRESCALER_RST;
            clr_a_r <= 1'b0;
            clr_b_r <= 1'b0;
            cap_sel_r <= 1'b0;
            smp_sel_r <= SAMPLING_RST;
            edge_mode_r <= EDGE_MODE_RST;
            cmp_a_r <= '0;
        end
        else if (wr_accept)
        begin
            case (I_AVS_ADDRESS)
                OFF_TIMER_CONTROL:
                    if (I_AVS_BYTEENABLE[0])
                        width_r <= I_AVS_WRITEDATA[TC_WIDTH_BIT];
                OFF_PRESCALER_SELECT:
                    if (I_AVS_BYTEENABLE[0])
                        prescale_r <= I_AVS_WRITEDATA[3:0];
                OFF_CC_CONTROL:
                    if (I_AVS_BYTEENABLE[0])
                    begin
                        clr_a_r <= I_AVS_WRITEDATA[CC_CLR_A_BIT];
                        clr_b_r <= I_AVS_WRITEDATA[CC_CLR_B_BIT];
                        cap_sel_r <= I_AVS_WRITEDATA[CC_CAPTURE_BIT];
                    end
                OFF_SAMPLING_SELECT:
                    if (I_AVS_BYTEENABLE[0])
                        smp_sel_r <= I_AVS_WRITEDATA[1:0];
                OFF_EDGE_MODE:
                    if (I_AVS_BYTEENABLE[0])
                        edge_mode_r <= I_AVS_WRITEDATA[1:0];
                OFF_COMPARE_A:
                    cmp_a_r <= merge16(cmp_a_r, I_AVS_WRITEDATA,
                        I_AVS_BYTEENABLE);
                default:
                begin
                end
            endcase
        end
    end

    // ************************************************************
    // prescaler and sampling enables
    // ************************************************************
    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
            div_r <= '0;
        else
            div_r <= div_r + 11'h001;
    end

    // selection n gives a count clock of fclk / 2^(n+3)
    assign pmask = PRESCALE_BASE_MASK >> (PRESCALE_MAX_SEL - prescale_r);
    assign int_tick = (prescale_r <= PRESCALE_MAX_SEL)
        && ((div_r & pmask) == pmask);

    always_comb
    begin
        case (smp_sel_r)
            SMP_FCLK: smp_en = 1'b1;
            SMP_DIV64: smp_en = ((div_r & SMP_MASK64) == SMP_MASK64);
            SMP_DIV128: smp_en = ((div_r & SMP_MASK128) == SMP_MASK128);
            default: smp_en = ((div_r & SMP_MASK256) == SMP_MASK256);
        endcase
    end

    // all three edge modes (falling, rising, both) share the same filter path
    edge_sampler u_edge_sampler (
        .i_clk(I_CLK),
        .i_rst_n(rst_n),
        .i_pin(I_EXTERNAL_EDGE_INPUT),
        .i_sample_en(smp_en),
        .i_edge_mode(edge_mode_r),
        .o_edge(edge_pulse)
    );

    assign count_tick = (prescale_r == PRESCALE_EXTERNAL)
        ? edge_pulse : int_tick;

    // ************************************************************
    // counter
    // ************************************************************
    assign wmask = width_r ? MASK_16 : MASK_8;
    assign cap_evt = edge_pulse && (state_r == ST_RUNNING);

    always_comb
    begin
        count_nxt = count_r;
        state_nxt = state_r;
        inc = 1'b0;
        consume = 1'b0;
        case (state_r)
            ST_STOPPED: count_nxt = COUNT_ZERO;
            ST_STARTING:
                if (count_tick)
                begin
                    count_nxt = COUNT_ZERO;
                    state_nxt = ST_RUNNING;
                end
            ST_RUNNING:
                if (step_clr_r)
                    count_nxt = COUNT_ZERO;
                else if (count_tick)
                begin
                    consume = 1'b1;
                    if (match_pend_r)
                        count_nxt = COUNT_ZERO;
                    else
                    begin
                        inc = 1'b1;
                        count_nxt = (count_r + COUNT_ONE) & wmask;
                    end
                end
            default: state_nxt = ST_STOPPED;
        endcase
        if (wr_tc)
        begin
            if (!I_AVS_WRITEDATA[TC_RUN_BIT])
            begin
                state_nxt = ST_STOPPED;
                count_nxt = COUNT_ZERO;
            end
            else if (state_r == ST_STOPPED)
                state_nxt = ST_STARTING;
        end
    end

    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_r <= '0;
            state_r <= ST_STOPPED;
        end
        else
        begin
            count_r <= count_nxt;
            state_r <= state_nxt;
        end
    end

    // ************************************************************
    // compare
    // ************************************************************
    // independent comparators on one counter
    assign match_a = inc && (count_nxt == (cmp_a_r & wmask));
    assign match_b = inc && !cap_sel_r
        && (count_nxt == (dual_r & wmask));
    assign ovf_evt = inc && ((count_r & wmask) == wmask);

    // ************************************************************
    // pending clears
    // ************************************************************
    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            match_pend_r <= 1'b0;
            cap_pend_r <= 1'b0;
            step_clr_r <= 1'b0;
        end
        else if (state_nxt != ST_RUNNING)
        begin
            match_pend_r <= 1'b0;
            cap_pend_r <= 1'b0;
            step_clr_r <= 1'b0;
        end
        else
        begin
            match_pend_r <= (match_pend_r && !consume)
                || (match_a && clr_a_r) || (match_b && clr_b_r);
            cap_pend_r <= (cap_pend_r && !consume)
                || (cap_evt && cap_sel_r && clr_b_r);
            step_clr_r <= consume && cap_pend_r && !match_pend_r;
        end
    end

    // ************************************************************
    // capture and dual register
    // ************************************************************
    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            capture_r <= '0;
            dual_r <= '0;
        end
        else
        begin
            if (cap_evt)
                capture_r <= count_r & wmask;
            // capture beats a bus write in the same cycle
            if (cap_evt && cap_sel_r)
                dual_r <= count_r & wmask;
            else if (wr_accept && (I_AVS_ADDRESS == OFF_DUAL))
                dual_r <= merge16(dual_r, I_AVS_WRITEDATA,
                    I_AVS_BYTEENABLE);
        end
    end

    // ************************************************************
    // overflow flag
    // ************************************************************
    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
            ovf_r <= 1'b0;
        else if (ovf_evt)
            ovf_r <= 1'b1;
        else if (wr_tc && !I_AVS_WRITEDATA[TC_OVF_BIT])
            ovf_r <= 1'b0;
    end

    // ************************************************************
    // request outputs
    // ************************************************************
    always_ff @(posedge I_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            O_MATCH_IRQ_A <= 1'b0;
            O_MATCH_IRQ_B <= 1'b0;
            O_EDGE_IRQ <= 1'b0;
        end
        else
        begin
            O_MATCH_IRQ_A <= match_a;
            O_MATCH_IRQ_B <= match_b;
            // edge request tells one edge from none
            O_EDGE_IRQ <= edge_pulse;
        end
    end

endmodule

// file: src/timer_pkg.sv
package timer_pkg;

    // ************************************************************
    // bus and datapath widths
    // ************************************************************
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int CNT_W = 16;
    localparam int DIV_W = 11;
    localparam int FILTER_LEN = 3;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFF_TIMER_CONTROL = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_PRESCALER_SELECT = 6'h04;
    localparam logic [ADDR_W-1:0] OFF_CC_CONTROL = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_SAMPLING_SELECT = 6'h0C;
    localparam logic [ADDR_W-1:0] OFF_EDGE_MODE = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_COMPARE_A = 6'h14;
    localparam logic [ADDR_W-1:0] OFF_DUAL = 6'h18;
    localparam logic [ADDR_W-1:0] OFF_CAPTURE = 6'h1C;
    localparam logic [ADDR_W-1:0] OFF_TIMER_COUNT = 6'h20;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int TC_WIDTH_BIT = 0;
    localparam int TC_OVF_BIT = 2;
    localparam int TC_RUN_BIT = 3;
    localparam int CC_CLR_A_BIT = 0;
    localparam int CC_CLR_B_BIT = 1;
    localparam int CC_CAPTURE_BIT = 2;

    // ************************************************************
    // reset values and encodings
    // ************************************************************
    localparam logic [3:0] PRESCALER_RST = 4'h1;
    localparam logic [1:0] SAMPLING_RST = 2'h0;
    localparam logic [1:0] EDGE_MODE_RST = 2'h0;
    localparam logic [3:0] PRESCALE_MAX_SEL = 4'h8;
    localparam logic [3:0] PRESCALE_EXTERNAL = 4'h9;
    localparam logic [DIV_W-1:0] PRESCALE_BASE_MASK = 11'h7FF;
    localparam logic [1:0] SMP_FCLK = 2'h0;
    localparam logic [1:0] SMP_DIV64 = 2'h1;
    localparam logic [1:0] SMP_DIV128 = 2'h2;
    localparam logic [DIV_W-1:0] SMP_MASK64 = 11'h03F;
    localparam logic [DIV_W-1:0] SMP_MASK128 = 11'h07F;
    localparam logic [DIV_W-1:0] SMP_MASK256 = 11'h0FF;
    localparam logic [1:0] EDGE_FALLING = 2'h0;
    localparam logic [1:0] EDGE_RISING = 2'h1;
    localparam logic [CNT_W-1:0] MASK_8 = 16'h00FF;
    localparam logic [CNT_W-1:0] MASK_16 = 16'hFFFF;
    localparam logic [CNT_W-1:0] COUNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] COUNT_ONE = 16'h0001;

    typedef enum logic [1:0] {ST_STOPPED, ST_STARTING, ST_RUNNING} cnt_state_e;

endpackage

// file: src/edge_sampler.sv
`timescale 1ns/1ps
module edge_sampler
    import timer_pkg::*;
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // pin and settings
    input wire logic i_pin,
    input wire logic i_sample_en,
    input wire logic [1:0] i_edge_mode,
    // detected valid edge
    output logic o_edge
);

    logic sync1_r;
    logic sync2_r;
    logic [FILTER_LEN-1:0] hist_r;
    logic level_r;
    logic level_nxt;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end
        else
        begin
            sync1_r <= i_pin;
            sync2_r <= sync1_r;
        end
    end

    always_comb
    begin
        level_nxt = level_r;
        if (i_sample_en && (hist_r == {FILTER_LEN{1'b1}}))
            level_nxt = 1'b1;
        else if (i_sample_en && (hist_r == {FILTER_LEN{1'b0}}))
            level_nxt = 1'b0;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            hist_r <= '0;
            level_r <= 1'b0;
            o_edge <= 1'b0;
        end
        else
        begin
            if (i_sample_en)
                hist_r <= {hist_r[FILTER_LEN-2:0], sync2_r};
            level_r <= level_nxt;
            case (i_edge_mode)
                EDGE_FALLING: o_edge <= level_r & ~level_nxt;
                EDGE_RISING: o_edge <= ~level_r & level_nxt;
                default: o_edge <= level_r ^ level_nxt;
            endcase
        end
    end

endmodule

// file: test/pulse_source.sv
`timescale 1ns/1ps
module pulse_source
(
    // clock
    input wire logic i_clk,
    // pulse pin, always driven
    output logic o_pin
);
    initial o_pin = 1'b0;

    task automatic pulses(input int n, input int w);
        repeat (n)
        begin
            repeat (w) @(posedge i_clk);
            o_pin <= 1'b1;
            repeat (w) @(posedge i_clk);
            o_pin <= 1'b0;
        end
        // let the filter settle for 2 * w + 12 cycles
        repeat (2 * w + 12) @(posedge i_clk);
    endtask
endmodule

// file: test/timer_capture_compare_unit_checker.sv
`timescale 1ns/1ps
module timer_capture_compare_unit_checker
    import timer_pkg::*;
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    // bus
    input wire logic I_AVS_READ,
    input wire logic I_AVS_WRITE,
    input wire logic [DATA_W-1:0] O_AVS_READDATA,
    input wire logic O_AVS_WAITREQUEST,
    // pin and requests
    input wire logic I_EXTERNAL_EDGE_INPUT,
    input wire logic O_MATCH_IRQ_A,
    input wire logic O_MATCH_IRQ_B,
    input wire logic O_EDGE_IRQ
);
    // ********
    // pin quiet time
    // ********
    // slowest sampling needs about 1030 cycles
    localparam int EDGE_LAT = 1100;
    logic [10:0] quiet_r;
    logic pin_r;

    always_ff @(posedge I_CLK or negedge I_RESET_N)
    begin
        if (!I_RESET_N)
        begin
            quiet_r <= 11'h000;
            pin_r <= 1'b0;
        end
        else
        begin
            pin_r <= I_EXTERNAL_EDGE_INPUT;
            if (I_EXTERNAL_EDGE_INPUT != pin_r)
                quiet_r <= 11'h000;
            else if (quiet_r != 11'h7FF)
                quiet_r <= quiet_r + 11'h001;
        end
    end

    // ********
    // properties
    // ********
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RESET_N);

    sequence s_ack;
        !O_AVS_WAITREQUEST ##1 O_AVS_WAITREQUEST;
    endsequence
    sequence s_gap2(sig);
        !sig [*2];
    endsequence

    property p_wait_answer;
        (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |=> s_ack;
    endproperty
    property p_idle;
        !I_AVS_READ && !I_AVS_WRITE && O_AVS_WAITREQUEST
            |=> O_AVS_WAITREQUEST;
    endproperty
    property p_ack_cause;
        $fell(O_AVS_WAITREQUEST)
            |-> $past(I_AVS_READ) || $past(I_AVS_WRITE);
    endproperty
    property p_rd_change;
        !$stable(O_AVS_READDATA) |-> !O_AVS_WAITREQUEST && I_AVS_READ;
    endproperty
    property p_irqa_gap;
        O_MATCH_IRQ_A |=> s_gap2(O_MATCH_IRQ_A);
    endproperty
    property p_irqb_gap;
        O_MATCH_IRQ_B |=> s_gap2(O_MATCH_IRQ_B);
    endproperty
    property p_edge_gap;
        O_EDGE_IRQ |=> s_gap2(O_EDGE_IRQ);
    endproperty
    property p_edge_cause;
        O_EDGE_IRQ |-> quiet_r < EDGE_LAT;
    endproperty

    a_wait_answer: assert property (p_wait_answer)
        else $error("request not accepted after one wait cycle");
    a_idle: assert property (p_idle)
        else $error("accept without request");
    a_ack_cause: assert property (p_ack_cause)
        else $error("waitrequest fell without request");
    a_rd_change: assert property (p_rd_change)
        else $error("read data changed outside read accept");
    a_irqa_gap: assert property (p_irqa_gap)
        else $error("match a request too long or too dense");
    a_irqb_gap: assert property (p_irqb_gap)
        else $error("match b request too long or too dense");
    a_edge_gap: assert property (p_edge_gap)
        else $error("edge requests closer than filter allows");
    a_edge_cause: assert property (p_edge_cause)
        else $error("edge request without pin change");
endmodule

bind timer_capture_compare_unit timer_capture_compare_unit_checker
    u_timer_capture_compare_unit_checker (
    .I_CLK(I_CLK),
    .I_RESET_N(I_RESET_N),
    .I_AVS_READ(I_AVS_READ),
    .I_AVS_WRITE(I_AVS_WRITE),
    .O_AVS_READDATA(O_AVS_READDATA),
    .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
    .I_EXTERNAL_EDGE_INPUT(I_EXTERNAL_EDGE_INPUT),
    .O_MATCH_IRQ_A(O_MATCH_IRQ_A),
    .O_MATCH_IRQ_B(O_MATCH_IRQ_B),
    .O_EDGE_IRQ(O_EDGE_IRQ)
);

// file: test/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import timer_pkg::*;
;
    typedef struct {string nm; logic [DATA_W-1:0] v;} note_s;
    logic clk;
    logic rst_n;
    logic [ADDR_W-1:0] addr;
    logic rd_en;
    logic wr_en;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic waitreq;
    logic pin;
    logic irq_a;
    logic irq_b;
    logic irq_e;
    logic [DATA_W-1:0] r;
    int bad_count;
    int checks_done;
    int n_a, n_b, n_e, b, ba, bb, k, e, cyc, t_a, t0;
    int seed;
    note_s notes[$];
    note_s nt;

    timer_capture_compare_unit u_timer_capture_compare_unit (
        .I_CLK(clk), .I_RESET_N(rst_n),
        .I_AVS_ADDRESS(addr), .I_AVS_READ(rd_en),
        .I_AVS_WRITE(wr_en), .I_AVS_WRITEDATA(wdata),
        .I_AVS_BYTEENABLE(4'hF), .O_AVS_READDATA(rdata),
        .O_AVS_WAITREQUEST(waitreq), .I_EXTERNAL_EDGE_INPUT(pin),
        .O_MATCH_IRQ_A(irq_a), .O_MATCH_IRQ_B(irq_b), .O_EDGE_IRQ(irq_e));
    pulse_source u_pulse_source (.i_clk(clk), .o_pin(pin));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ********
    // tasks
    // ********
    task automatic chk(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
        checks_done++;
        if (g !== x)
        begin
            $display("[ERR] %s expected %h seen %h", nm, x, g);
            bad_count++;
        end
    endtask

    task automatic bus(input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, input logic w);
        addr <= a;
        wdata <= d;
        wr_en <= w;
        rd_en <= !w;
        @(posedge clk);
        while (waitreq !== 1'b0) @(posedge clk);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input int d);
        bus(a, DATA_W'(d), 1'b1);
    endtask

    task automatic rd(input string nm, input logic [ADDR_W-1:0] a,
                      input int x);
        notes.push_back('{nm, DATA_W'(x)});
        bus(a, '0, 1'b0);
    endtask

    task automatic run(input int on, input int wide);
        wr(OFF_TIMER_CONTROL, on * 8 + wide);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ********
    // watcher: read results against notes
    // ********
    always @(posedge clk)
    begin
        cyc++;
        if (irq_a === 1'b1)
            t_a = cyc;
        n_a += (irq_a === 1'b1);
        n_b += (irq_b === 1'b1);
        n_e += (irq_e === 1'b1);
        if (rd_en === 1'b1 && waitreq === 1'b0)
        begin
            nt = notes.pop_front();
            chk(nt.nm, nt.v, rdata);
        end
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        bad_count++;
        final_report;
    end

    // ********
    // tests
    // ********
    initial
    begin
        seed = 32'h4EA4B6EA;
        rst_n = 1'b0;
        addr = '0;
        rd_en = 1'b0;
        wr_en = 1'b0;
        wdata = '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 10; i++)
            rd("reset value", ADDR_W'(4 * i), (i == 1) ? 1 : 0);
        $display("test reset values done");

        wr(OFF_PRESCALER_SELECT, 9);
        for (int m = 0; m < 3; m++)
        begin
            // first pass: a single edge still reads zero
            k = (m == 0) ? 1 : 1 + ($random(seed) & 3);
            e = (m == 2) ? 2 * k : k;
            wr(OFF_EDGE_MODE, m);
            run(1, 1);
            b = n_e;
            u_pulse_source.pulses(k, 3);
            rd("event count", OFF_TIMER_COUNT, e - 1);
            chk("edge irqs", e, n_e - b);
            run(1, 1);
            u_pulse_source.pulses(1, 3);
            rd("count after rewrite", OFF_TIMER_COUNT, e + (m == 2));
            run(0, 1);
            rd("count after stop", OFF_TIMER_COUNT, 0);
        end
        $display("test event counting done");

        run(1, 0);
        u_pulse_source.pulses(129, 3);
        rd("wrapped count", OFF_TIMER_COUNT, 1);
        rd("overflow set", OFF_TIMER_CONTROL, 12);
        run(1, 0);
        rd("overflow cleared", OFF_TIMER_CONTROL, 8);
        run(0, 0);
        $display("test overflow done");

        wr(OFF_EDGE_MODE, 1);
        wr(OFF_COMPARE_A, 3);
        wr(OFF_DUAL, 2);
        wr(OFF_CC_CONTROL, 1);
        run(1, 1);
        ba = n_a;
        bb = n_b;
        u_pulse_source.pulses(12, 3);
        rd("count held at match", OFF_TIMER_COUNT, 3);
        u_pulse_source.pulses(1, 3);
        rd("count after clear", OFF_TIMER_COUNT, 0);
        chk("match a irqs", 3, n_a - ba);
        chk("match b irqs", 3, n_b - bb);
        run(0, 1);
        r = $random(seed);
        wr(OFF_DUAL, r);
        rd("dual compare value", OFF_DUAL, r[15:0]);
        $display("test compare done");

        wr(OFF_CC_CONTROL, 4);
        run(1, 1);
        u_pulse_source.pulses(5, 3);
        rd("capture reg", OFF_CAPTURE, 3);
        rd("dual captured", OFF_DUAL, 3);
        run(0, 1);
        wr(OFF_COMPARE_A, 1);
        wr(OFF_CC_CONTROL, 6);
        run(1, 1);
        ba = n_a;
        u_pulse_source.pulses(4, 3);
        rd("count after capture", OFF_TIMER_COUNT, 0);
        // each capture edge also ticks, so two steps land on one
        chk("extra match irqs", 2, n_a - ba);
        run(0, 1);
        $display("test capture done");

        // free-running count at fclk/8, step of 20 per match
        wr(OFF_PRESCALER_SELECT, 0);
        wr(OFF_CC_CONTROL, 0);
        wr(OFF_COMPARE_A, 20);
        run(1, 1);
        for (int j = 1; j < 5; j++)
        begin
            ba = n_a;
            while (n_a == ba) @(posedge clk);
            if (j > 1)
                chk("match interval", 160, t_a - t0);
            t0 = t_a;
            wr(OFF_COMPARE_A, 20 * (j + 1));
        end
        run(0, 1);
        $display("test interval done");

        wr(OFF_SAMPLING_SELECT, 1);
        wr(OFF_EDGE_MODE, 2);
        b = n_e;
        u_pulse_source.pulses(1, 200);
        chk("slow sampled edges", 2, n_e - b);
        b = n_e;
        u_pulse_source.pulses(1, 20);
        chk("short pulse edges", 0, n_e - b);
        $display("test sampling done");
        final_report;
    end
endmodule
